// ### lpt_consts.svh
/*
 Constants of the linear page translator: control bit positions,
 entry field positions, linear address split and walk sizes.
 Assumes nothing; included by the package users.
*/
`ifndef LPT_CONSTS_SVH
`define LPT_CONSTS_SVH

// ============================================================
// Control words
`define LPT_CW0_TRANSLATE_BIT 31
`define LPT_CW4_LARGE_BIT 4
`define LPT_CW4_EXT_BIT 5
`define LPT_QUERY_LEAF 32'h0000_0001
`define LPT_QUERY_LP36_BIT 17

// ============================================================
// Entry fields
`define LPT_PRESENT_BIT 0
`define LPT_SIZE_BIT 7
`define LPT_DIR_ENTRIES 1024
`define LPT_PTR_ENTRIES 4
`define LPT_LP36_LO 13
`define LPT_LP36_HI 16

// ============================================================
// Linear address split
`define LPT_DIR_HI 31
`define LPT_DIR_LO 22
`define LPT_TBL_HI 21
`define LPT_TBL_LO 12
`define LPT_OFS_HI 11
`define LPT_BIG_OFS_HI 21
`define LPT_MID_OFS_HI 20
`define LPT_PTR_HI 31
`define LPT_PTR_LO 30
`define LPT_XDIR_HI 29
`define LPT_XDIR_LO 21
`define LPT_XTBL_HI 20
`define LPT_XTBL_LO 12

`endif

// ### lpt_pkg.sv
/*
 Types of the linear page translator.
 Assumes lpt_consts.svh sits in the include path.
*/
package lpt_pkg;
	typedef struct packed
	{
		logic translate_enable;
		logic large_page_enable;
		logic addr_extension_enable;
		logic large_page_36bit_ext;
	} lpt_mode_t;

	typedef enum logic [2:0]
	{
		LPT_IDLE = 3'b000,
		LPT_PTR = 3'b001,
		LPT_DIR = 3'b010,
		LPT_TBL = 3'b011,
		LPT_DONE = 3'b100,
		LPT_FAULT = 3'b101
	} lpt_state_t;

	typedef enum logic [1:0]
	{
		LPT_PG_NONE = 2'b00,
		LPT_PG_4K = 2'b01,
		LPT_PG_2M = 2'b10,
		LPT_PG_4M = 2'b11
	} lpt_page_t;
endpackage

// ### lpt_mode_decode.sv
/*
 Decodes control words into the translation mode and answers the
 identification query bit for the 36-bit large page extension.
 Assumes control words are registered on the same clock.
*/
`timescale 1ns/1ns
`include "lpt_consts.svh"
module lpt_mode_decode
	import lpt_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control words and capability
	input wire logic [31:0] control_word_zero,
	input wire logic [31:0] control_word_four,
	input wire logic lp36_capable,
	input wire logic [31:0] ident_query,
	// Results
	output lpt_mode_t mode,
	output logic [31:0] query_result_word
);
	// ============================================================
	// Mode register
	always_ff @(posedge clk)
	begin
		if (srst)
			mode <= '0;
		else
		begin
			mode.translate_enable <= control_word_zero[`LPT_CW0_TRANSLATE_BIT];
			mode.large_page_enable <= control_word_four[`LPT_CW4_LARGE_BIT];
			// Extension only acts under translation
			mode.addr_extension_enable <= control_word_four[`LPT_CW4_EXT_BIT]
				& control_word_zero[`LPT_CW0_TRANSLATE_BIT];
			mode.large_page_36bit_ext <= lp36_capable;
		end
	end

	// ============================================================
	// Identification answer
	always_ff @(posedge clk)
	begin
		if (srst)
			query_result_word <= 32'h0000_0000;
		else
		begin
			query_result_word <= 32'h0000_0000;
			if (ident_query == `LPT_QUERY_LEAF)
				query_result_word[`LPT_QUERY_LP36_BIT] <= lp36_capable;
		end
	end
endmodule

// ### lpt_translator.sv
/*
 Linear page translator: walks pointer table, directory and table
 in memory and forms 32- or 36-bit physical addresses.
 Assumes a core request/answer handshake and a table memory that
 answers one read at a time with rd_valid, any latency.
*/
// Functional notes
// - Address extension acts only with translation on; addresses up to 36 bits.
// - Extension adds a pointer-table level ahead of directory and table.
// - Query leaf 1 reports 36-bit large page support at bit 17.
// - Directory is one 4 KB page of 1024 32-bit entries.
// - Table is one 4 KB page of 1024 entries, each locating a page.
// - 2 MB and 4 MB pages map from directory entry, no table fetch.
// - Extension uses four 64-bit pointer entries, each locating a directory.
// - Size bit 0 means table; 1 means 4 MB or 2 MB page.
// - Page and address size follow the enable flags and capability.
// - Linear bits 31..22 index the directory for small pages.
// - Linear bits 21..12 index the table; entry gives page base.
// - Linear bits 11..0 are the byte offset in small pages.
// - 4 MB pages need large page enable and size bit both set.
// - 4 MB pages: directory entry base, bits 21..0 offset.
// - Large pages off: every directory entry is a table pointer; with extension on, a set size bit still maps a 2 MB page.
// - Translation enable is control word zero bit 31.
// - Large page enable bit 4, extension enable bit 5 of word four.
// - Clear presence bit aborts the walk with a page fault.
// - Small-page entry base is the top 20 physical bits.
`timescale 1ns/1ns
`include "lpt_consts.svh"
module lpt_translator
	import lpt_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic [31:0] control_word_zero,
	input wire logic [31:0] control_word_four,
	input wire logic [31:0] table_base,
	input wire logic lp36_capable,
	input wire logic [31:0] ident_query,
	output logic [31:0] query_result_word,
	// Core request
	input wire logic req_valid,
	input wire logic [31:0] req_linear,
	output logic req_ready,
	// Core answer
	output logic resp_valid,
	output logic [35:0] resp_phys,
	output logic [1:0] resp_page,
	output logic page_missing_fault,
	// Table memory
	output logic rd_req,
	output logic [35:0] rd_addr,
	input wire logic rd_valid,
	input wire logic [63:0] rd_data
);
	lpt_mode_t mode;
	lpt_state_t state;
	logic [31:0] lin;
	logic [35:0] ptr_base;
	logic [35:0] tbl_base;
	logic [63:0] entry;
	logic [35:0] leaf_base;

	lpt_mode_decode u_mode
	(
		.clk(clk),
		.srst(srst),
		.control_word_zero(control_word_zero),
		.control_word_four(control_word_four),
		.lp36_capable(lp36_capable),
		.ident_query(ident_query),
		.mode(mode),
		.query_result_word(query_result_word)
	);

	// Base of a 4 KB aligned structure from an entry
	function automatic logic [35:0] page_base(input logic [63:0] e, input logic ext);
		page_base = ext ? {e[35:12], 12'h000} : {4'h0, e[31:12], 12'h000};
	endfunction

	// Base of the entry being read, used by the final table step
	assign leaf_base = page_base(rd_data, mode.addr_extension_enable);

	// ============================================================
	// Walk state machine
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= LPT_IDLE;
			lin <= 32'h0000_0000;
			tbl_base <= 36'h0_0000_0000;
			ptr_base <= 36'h0_0000_0000;
			req_ready <= 1'b0;
			rd_req <= 1'b0;
			rd_addr <= 36'h0_0000_0000;
			resp_valid <= 1'b0;
			resp_phys <= 36'h0_0000_0000;
			resp_page <= LPT_PG_NONE;
			page_missing_fault <= 1'b0;
			entry <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			rd_req <= 1'b0;
			resp_valid <= 1'b0;
			page_missing_fault <= 1'b0;
			case (state)
			LPT_IDLE:
			begin
				req_ready <= 1'b1;
				if (req_valid && req_ready)
				begin
					req_ready <= 1'b0;
					lin <= req_linear;
					if (!mode.translate_enable)
					begin
						// Paging off: pass through
						resp_valid <= 1'b1;
						resp_phys <= {4'h0, req_linear};
						resp_page <= LPT_PG_NONE;
						// Same refusal window as a walk answer
						state <= LPT_DONE;
					end
					else if (mode.addr_extension_enable)
					begin
						// Four 8-byte pointers, 32-byte aligned
						rd_req <= 1'b1;
						rd_addr <= {4'h0, table_base[31:5],
							req_linear[`LPT_PTR_HI:`LPT_PTR_LO], 3'b000};
						state <= LPT_PTR;
					end
					else
					begin
						rd_req <= 1'b1;
						rd_addr <= {4'h0, table_base[31:12],
							req_linear[`LPT_DIR_HI:`LPT_DIR_LO], 2'b00};
						state <= LPT_DIR;
					end
				end
			end
			LPT_PTR:
				if (rd_valid)
				begin
					if (!rd_data[`LPT_PRESENT_BIT])
						state <= LPT_FAULT;
					else
					begin
						ptr_base <= page_base(rd_data, 1'b1);
						rd_req <= 1'b1;
						rd_addr <= {rd_data[35:12],
							lin[`LPT_XDIR_HI:`LPT_XDIR_LO], 3'b000};
						state <= LPT_DIR;
					end
				end
			LPT_DIR:
				if (rd_valid)
				begin
					entry <= rd_data;
					if (!rd_data[`LPT_PRESENT_BIT])
						state <= LPT_FAULT;
					else if (mode.addr_extension_enable && rd_data[`LPT_SIZE_BIT])
					begin
						// 2 MB page, no table fetch
						resp_valid <= 1'b1;
						resp_phys <= {rd_data[35:21], lin[`LPT_MID_OFS_HI:0]};
						resp_page <= LPT_PG_2M;
						state <= LPT_DONE;
					end
					else if (!mode.addr_extension_enable && mode.large_page_enable
						&& rd_data[`LPT_SIZE_BIT])
					begin
						resp_valid <= 1'b1;
						resp_page <= LPT_PG_4M;
						if (mode.large_page_36bit_ext)
							resp_phys <= {rd_data[`LPT_LP36_HI:`LPT_LP36_LO],
								rd_data[31:22], lin[`LPT_BIG_OFS_HI:0]};
						else
							resp_phys <= {4'h0, rd_data[31:22],
								lin[`LPT_BIG_OFS_HI:0]};
						state <= LPT_DONE;
					end
					else
					begin
						// Size bit ignored with large pages and extension both off
						tbl_base <= page_base(rd_data, mode.addr_extension_enable);
						rd_req <= 1'b1;
						if (mode.addr_extension_enable)
							rd_addr <= {rd_data[35:12],
								lin[`LPT_XTBL_HI:`LPT_XTBL_LO], 3'b000};
						else
							rd_addr <= {4'h0, rd_data[31:12],
								lin[`LPT_TBL_HI:`LPT_TBL_LO], 2'b00};
						state <= LPT_TBL;
					end
				end
			LPT_TBL:
				if (rd_valid)
				begin
					entry <= rd_data;
					if (!rd_data[`LPT_PRESENT_BIT])
						state <= LPT_FAULT;
					else
					begin
						resp_valid <= 1'b1;
						resp_phys <= {leaf_base[35:12], lin[`LPT_OFS_HI:0]};
						resp_page <= LPT_PG_4K;
						state <= LPT_DONE;
					end
				end
			LPT_FAULT:
			begin
				resp_valid <= 1'b1;
				page_missing_fault <= 1'b1;
				resp_phys <= 36'h0_0000_0000;
				resp_page <= LPT_PG_NONE;
				state <= LPT_DONE;
			end
			LPT_DONE:
				state <= LPT_IDLE;
			default:
				state <= LPT_IDLE;
			endcase
		end
	end
endmodule

// ### lpt_check_sva.sv
/*
 Port checker of the page translator.
 Assumes control words and table base hold steady while a walk runs.
*/
`timescale 1ns/1ns
module lpt_check (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic [31:0] control_word_zero,
	input wire logic [31:0] control_word_four,
	input wire logic [31:0] table_base,
	input wire logic lp36_capable,
	input wire logic [31:0] ident_query,
	input wire logic [31:0] query_result_word,
	// Core side
	input wire logic req_valid,
	input wire logic [31:0] req_linear,
	input wire logic req_ready,
	input wire logic resp_valid,
	input wire logic [35:0] resp_phys,
	input wire logic [1:0] resp_page,
	input wire logic page_missing_fault,
	// Table memory
	input wire logic rd_req,
	input wire logic [35:0] rd_addr,
	input wire logic rd_valid
);
	// ============================================================
	// Properties
	logic [31:0] lin_q;
	always_ff @(posedge clk)
		lin_q <= req_linear;
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_take;
		req_valid && req_ready;
	endsequence
	a_bypass_answer: assert property (s_take ##0 !control_word_zero[31] |=>
		resp_valid && !rd_req && resp_phys == {4'h0, lin_q})
		else $error("bypass answer wrong");
	a_dir_index: assert property (s_take ##0 control_word_zero[31] &&
		!control_word_four[5] |=> rd_req && rd_addr == {4'h0, table_base[31:12], lin_q[31:22], 2'h0})
		else $error("directory read address wrong");
	a_ptr_index: assert property (s_take ##0 control_word_zero[31] &&
		control_word_four[5] |=> rd_req && rd_addr == {4'h0, table_base[31:5], lin_q[31:30], 3'h0})
		else $error("pointer read address wrong");
	a_query_bit: assert property (ident_query == 32'h0000_0001 |=>
		query_result_word == {14'h0000, $past(lp36_capable), 17'h0_0000})
		else $error("query bit wrong");
	a_refuse_taken: assert property (s_take |=> !req_ready [*2])
		else $error("request accepted during walk");
	a_one_read: assert property (rd_req |=> !rd_req)
		else $error("read not a pulse");
	a_answer_read: assert property (resp_valid && resp_page != 2'h0 |-> $past(rd_valid))
		else $error("walk answer not after read");
	a_fault_answer: assert property (page_missing_fault |->
		resp_valid && resp_page == 2'h0 && $past(rd_valid, 2))
		else $error("fault answer wrong");
	a_answer_gap: assert property (resp_valid |=> !resp_valid [*2])
		else $error("answer not a pulse");
endmodule
bind lpt_translator lpt_check lpt_check_i (.clk(clk), .srst(srst),
	.control_word_zero(control_word_zero), .control_word_four(control_word_four),
	.table_base(table_base), .lp36_capable(lp36_capable), .ident_query(ident_query),
	.query_result_word(query_result_word), .req_valid(req_valid), .req_linear(req_linear),
	.req_ready(req_ready), .resp_valid(resp_valid), .resp_phys(resp_phys),
	.resp_page(resp_page), .page_missing_fault(page_missing_fault), .rd_req(rd_req),
	.rd_addr(rd_addr), .rd_valid(rd_valid));

// ### lpt_mem_model.sv
/*
 Table memory model: one read at a time, latency alternating short and long.
 Assumes the bench fills mem before walks; missing entries read as zero.
*/
`timescale 1ns/1ns
module lpt_mem_model (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Read port
	input wire logic rd_req,
	input wire logic [35:0] rd_addr,
	output logic rd_valid,
	output logic [63:0] rd_data
);
	// ============================================================
	// Storage and answer
	logic [63:0] mem [bit [35:0]];
	logic [35:0] addr_q;
	logic [1:0] wait_cnt;
	logic pending;
	logic slow;
	always_ff @(posedge clk)
	begin
		rd_valid <= 1'b0;
		rd_data <= ~rd_data;
		if (srst)
		begin
			pending <= 1'b0;
			slow <= 1'b0;
			rd_data <= 64'h0000_0000_0000_0000;
		end
		else if (rd_req)
		begin
			pending <= 1'b1;
			addr_q <= rd_addr;
			wait_cnt <= slow ? 2'h2 : 2'h0;
			slow <= !slow;
		end
		else if (pending && wait_cnt != 2'h0)
			wait_cnt <= wait_cnt - 2'h1;
		else if (pending)
		begin
			pending <= 1'b0;
			rd_valid <= 1'b1;
			rd_data <= mem.exists(addr_q) ? mem[addr_q] : 64'h0000_0000_0000_0000;
		end
	end
endmodule

// ### tb_linear_page_translator.sv
/*
 Bench of the page translator: walks of every page size, fault, query.
 Assumes lpt_translator, its checker and the memory model compiled first.
*/
`timescale 1ns/1ns
module tb_linear_page_translator;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [31:0] control_word_zero = 32'h0000_0000;
	logic [31:0] control_word_four = 32'h0000_0000;
	logic [31:0] table_base = 32'h0001_0000;
	logic lp36_capable = 1'b0;
	logic [31:0] ident_query = 32'h0000_0000;
	logic [31:0] query_result_word;
	logic req_valid = 1'b0;
	logic [31:0] req_linear = 32'h0000_0000;
	logic req_ready, resp_valid, page_missing_fault, rd_req, rd_valid;
	logic [35:0] resp_phys, rd_addr;
	logic [1:0] resp_page;
	logic [63:0] rd_data;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	lpt_translator lpt_translator_i (.clk(clk), .srst(srst),
		.control_word_zero(control_word_zero), .control_word_four(control_word_four),
		.table_base(table_base), .lp36_capable(lp36_capable), .ident_query(ident_query),
		.query_result_word(query_result_word), .req_valid(req_valid),
		.req_linear(req_linear), .req_ready(req_ready), .resp_valid(resp_valid),
		.resp_phys(resp_phys), .resp_page(resp_page),
		.page_missing_fault(page_missing_fault), .rd_req(rd_req), .rd_addr(rd_addr),
		.rd_valid(rd_valid), .rd_data(rd_data));
	lpt_mem_model lpt_mem_model_i (.clk(clk), .srst(srst), .rd_req(rd_req),
		.rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
	// ============================================================
	// Tasks
	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic xlate(input logic [31:0] lin, input logic [35:0] ep, input logic [1:0] pg,
		input logic f);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req_linear <= lin;
		n = 0;
		do @(posedge clk); while (req_ready !== 1'b1 && ++n < 50);
		if (n >= 50)
			err_count++;
		req_valid <= 1'b0;
		n = 0;
		do @(posedge clk); while (resp_valid !== 1'b1 && ++n < 50);
		if (n >= 50)
			err_count++;
		if (!f)
			check(resp_phys, ep);
		check({34'h0, resp_page}, {34'h0, pg});
		check({35'h0, page_missing_fault}, {35'h0, f});
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			report_and_stop;
		end
	end
	// ============================================================
	// Scenarios
	initial
	begin
		lpt_mem_model_i.mem[36'h0_0001_0004] = 64'h0000_0000_0002_0001;
		lpt_mem_model_i.mem[36'h0_0002_000C] = 64'h0000_0000_0ABC_D001;
		lpt_mem_model_i.mem[36'h0_0001_0008] = 64'h0000_0000_8040_A081;
		lpt_mem_model_i.mem[36'h0_8040_A00C] = 64'h0000_0000_0BBB_B001;
		lpt_mem_model_i.mem[36'h0_0003_0008] = 64'h0000_0004_0000_0001;
		lpt_mem_model_i.mem[36'h4_0000_0008] = 64'h0000_0007_0020_0081;
		lpt_mem_model_i.mem[36'h4_0000_0010] = 64'h0000_0005_0006_0001;
		lpt_mem_model_i.mem[36'h5_0006_0018] = 64'h0000_0009_ABCD_E001;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		xlate(32'h1234_5678, 36'h0_1234_5678, 2'h0, 1'b0);
		control_word_zero <= 32'h8000_0000;
		xlate(32'h0040_3123, 36'h0_0ABC_D123, 2'h1, 1'b0);
		xlate(32'h0080_3123, 36'h0_0BBB_B123, 2'h1, 1'b0);
		// Every request walks afresh, so nothing stale survives the toggle
		control_word_four <= 32'h0000_0010;
		xlate(32'h0080_3123, 36'h0_8040_3123, 2'h3, 1'b0);
		xlate(32'h0040_3123, 36'h0_0ABC_D123, 2'h1, 1'b0);
		lp36_capable <= 1'b1;
		xlate(32'h0080_3123, 36'h5_8040_3123, 2'h3, 1'b0);
		xlate(32'h00C0_0000, 36'h0_0000_0000, 2'h0, 1'b1);
		table_base <= 32'h0003_0000;
		control_word_four <= 32'h0000_0020;
		xlate(32'h4020_0456, 36'h7_0020_0456, 2'h2, 1'b0);
		xlate(32'h4040_3789, 36'h9_ABCD_E789, 2'h1, 1'b0);
		control_word_zero <= 32'h0000_0000;
		xlate(32'h4020_0456, 36'h0_4020_0456, 2'h0, 1'b0);
		ident_query <= 32'h0000_0001;
		repeat (2) @(posedge clk);
		check({4'h0, query_result_word}, 36'h0_0002_0000);
		ident_query <= 32'h0000_0002;
		repeat (2) @(posedge clk);
		check({4'h0, query_result_word}, 36'h0_0000_0000);
		ident_query <= 32'h0000_0001;
		lp36_capable <= 1'b0;
		repeat (2) @(posedge clk);
		check({4'h0, query_result_word}, 36'h0_0000_0000);
		report_and_stop;
	end
endmodule
